// >>> logic/srs_pkg.sv
package srs_pkg;
    // system clock rate and pulse capture
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned HARD_RESET_MIN_NS = 200;
    // a low pulse shorter than this may be missed; count rounds up
    localparam int unsigned HARD_RESET_CYC = (HARD_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    // supply and pin thresholds in millivolts, compared by the analog monitors
    localparam int unsigned CORE_SUPPLY_MIN_MV = 2720;
    localparam int unsigned PD_VIH_MIN_MV = 1200;
    // three-level strap encoding
    localparam logic [1:0] TRI_LOW = 2'h0;
    localparam logic [1:0] TRI_MID = 2'h1;
    localparam logic [1:0] TRI_HIGH = 2'h2;
    // reset values
    localparam logic RST_IFACE_SPI = 1'b0;
    localparam logic [1:0] RST_STRAP = 2'h0;

    typedef enum logic [2:0] {
        SRS_OFF,
        SRS_SAMPLE,
        SRS_LOAD,
        SRS_CAL,
        SRS_PLL,
        SRS_RUN
    } srs_state_e;

    typedef struct packed {
        logic [1:0] page_a;
        logic [1:0] page_b;
    } srs_page_s;

    typedef struct packed {
        logic sck;
        logic sdi;
    } srs_serial_s;
endpackage

// >>> logic/srs_startup_reset_sequencer.sv
`timescale 1ns/10ps
// Function
// - while power_down_n is low the device stays powered down and serial traffic is ignored.
// - a rising edge of power_down_n starts the power-on-reset sequence through to normal operation.
// - the interface-select strap is sampled at start-up, high selecting SPI and low I2C, held stable by the host.
// - the two ROM-page straps are sampled at start-up as three-level inputs and pick ROM page or EEPROM.
// - after reset the shared clock and data pins route to the SPI or I2C engine as latched.
// - the device stays in reset until core supplies exceed 2.72V and power_down_n exceeds 1.2V.
// - a soft reset during PLL start-up or normal operation re-runs oscillator calibration and PLL start-up.
// - the resonator APLL tolerates an invalid reference and locks once a valid one appears.
module srs_startup_reset_sequencer
(
    input wire logic clk,
    input wire logic rst,
    input wire logic power_down_n,
    input wire logic core_supply_ok,
    input wire logic interface_select_strap,
    input wire srs_pkg::srs_page_s rom_page_strap,
    input wire logic soft_reset_bit,
    input wire logic load_done,
    input wire logic cal_done,
    input wire logic xo_valid,
    input wire logic apll_lock,
    input wire srs_pkg::srs_serial_s serial_pins,
    output logic device_enable,
    output logic iface_is_spi,
    output srs_pkg::srs_page_s rom_page,
    output logic use_eeprom,
    output logic load_start,
    output logic cal_start,
    output logic pll_start,
    output logic normal_operation,
    output srs_pkg::srs_serial_s spi_pins,
    output srs_pkg::srs_serial_s i2c_pins
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pd_sync_q, pd_sync_d;
    logic [2:0] sup_sync_q, sup_sync_d;
    logic [2:0] sel_sync_q, sel_sync_d;
    srs_pkg::srs_page_s [2:0] pg_sync_q, pg_sync_d;
    logic pd_level_q, pd_level_d;
    logic sup_level_q, sup_level_d;
    logic sel_level_q, sel_level_d;
    srs_pkg::srs_page_s pg_level_q, pg_level_d;

    always_comb
    begin
        pd_sync_d = {pd_sync_q[1:0], power_down_n};
        sup_sync_d = {sup_sync_q[1:0], core_supply_ok};
        // straps are board pins as well, so they pass the same filter before sampling
        sel_sync_d = {sel_sync_q[1:0], interface_select_strap};
        pg_sync_d = {pg_sync_q[1:0], rom_page_strap};
        // a change counts only once stages two and three agree
        pd_level_d = (pd_sync_q[2] == pd_sync_q[1]) ? pd_sync_q[2] : pd_level_q;
        sup_level_d = (sup_sync_q[2] == sup_sync_q[1]) ? sup_sync_q[2] : sup_level_q;
        sel_level_d = (sel_sync_q[2] == sel_sync_q[1]) ? sel_sync_q[2] : sel_level_q;
        pg_level_d = (pg_sync_q[2] == pg_sync_q[1]) ? pg_sync_q[2] : pg_level_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pd_sync_q <= 3'h0;
            sup_sync_q <= 3'h0;
            sel_sync_q <= 3'h0;
            pg_sync_q <= '0;
            pd_level_q <= 1'b0;
            sup_level_q <= 1'b0;
            sel_level_q <= srs_pkg::RST_IFACE_SPI;
            pg_level_q <= '{page_a: srs_pkg::RST_STRAP, page_b: srs_pkg::RST_STRAP};
        end
        else
        begin
            pd_sync_q <= pd_sync_d;
            sup_sync_q <= sup_sync_d;
            sel_sync_q <= sel_sync_d;
            pg_sync_q <= pg_sync_d;
            pd_level_q <= pd_level_d;
            sup_level_q <= sup_level_d;
            sel_level_q <= sel_level_d;
            pg_level_q <= pg_level_d;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    srs_pkg::srs_state_e state_q, state_d;
    logic iface_q, iface_d;
    srs_pkg::srs_page_s page_q, page_d;
    logic soft_q, soft_d;
    logic hold_reset;
    logic soft_edge;

    // the host must hold low longer than the capture time so the filter sees it
    assign hold_reset = !pd_level_q || !sup_level_q;
    assign soft_edge = soft_reset_bit && !soft_q;

    always_comb
    begin
        state_d = state_q;
        iface_d = iface_q;
        page_d = page_q;
        soft_d = soft_reset_bit;
        if (hold_reset)
        begin
            state_d = srs_pkg::SRS_OFF;
        end
        else
        begin
            case (state_q)
                srs_pkg::SRS_OFF:
                begin
                    // leaving off happens as soon as the filtered pin and supplies are both seen good
                    state_d = srs_pkg::SRS_SAMPLE;
                end
                srs_pkg::SRS_SAMPLE:
                begin
                    iface_d = sel_level_q;
                    page_d = pg_level_q;
                    state_d = srs_pkg::SRS_LOAD;
                end
                srs_pkg::SRS_LOAD:
                begin
                    if (load_done)
                        state_d = srs_pkg::SRS_CAL;
                end
                srs_pkg::SRS_CAL:
                begin
                    // calibration relies on a stable oscillator kept by the system
                    if (cal_done)
                        state_d = srs_pkg::SRS_PLL;
                end
                srs_pkg::SRS_PLL:
                begin
                    // the resonator loop may wait for a valid reference before lock
                    if (xo_valid && apll_lock)
                        state_d = srs_pkg::SRS_RUN;
                end
                srs_pkg::SRS_RUN:
                begin
                    if (soft_edge)
                        state_d = srs_pkg::SRS_CAL;
                end
                default:
                begin
                    state_d = srs_pkg::SRS_OFF;
                end
            endcase
            // soft reset during pll start-up also restarts calibration
            if (soft_edge && (state_q == srs_pkg::SRS_PLL))
                state_d = srs_pkg::SRS_CAL;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= srs_pkg::SRS_OFF;
            iface_q <= srs_pkg::RST_IFACE_SPI;
            page_q <= '{page_a: srs_pkg::RST_STRAP, page_b: srs_pkg::RST_STRAP};
            soft_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            iface_q <= iface_d;
            page_q <= page_d;
            soft_q <= soft_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic en_q, en_d;
    logic load_go_q, load_go_d;
    logic cal_go_q, cal_go_d;
    logic pll_go_q, pll_go_d;
    logic run_q, run_d;

    // one-cycle start pulses on entry of the load, cal and pll phases, taken from the next state
    // so that each pulse lines up with the first cycle spent in its phase
    always_comb
    begin
        en_d = (state_d != srs_pkg::SRS_OFF);
        load_go_d = (state_d == srs_pkg::SRS_LOAD) && (state_q != srs_pkg::SRS_LOAD);
        cal_go_d = (state_d == srs_pkg::SRS_CAL) && (state_q != srs_pkg::SRS_CAL);
        pll_go_d = (state_d == srs_pkg::SRS_PLL) && (state_q != srs_pkg::SRS_PLL);
        run_d = (state_d == srs_pkg::SRS_RUN);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            en_q <= 1'b0;
            load_go_q <= 1'b0;
            cal_go_q <= 1'b0;
            pll_go_q <= 1'b0;
            run_q <= 1'b0;
        end
        else
        begin
            en_q <= en_d;
            load_go_q <= load_go_d;
            cal_go_q <= cal_go_d;
            pll_go_q <= pll_go_d;
            run_q <= run_d;
        end
    end

    assign device_enable = en_q;
    assign load_start = load_go_q;
    assign cal_start = cal_go_q;
    assign pll_start = pll_go_q;
    assign normal_operation = run_q;

    assign iface_is_spi = iface_q;
    assign rom_page = page_q;
    // mid level on either strap selects the eeprom image; low and high pick rom pages
    assign use_eeprom = (page_q.page_a == srs_pkg::TRI_MID) || (page_q.page_b == srs_pkg::TRI_MID);

    // serial pins are gated off while powered down so no traffic reaches either engine
    always_comb
    begin
        spi_pins = '{sck: 1'b0, sdi: 1'b0};
        i2c_pins = '{sck: 1'b1, sdi: 1'b1};
        if (device_enable && (state_q != srs_pkg::SRS_SAMPLE))
        begin
            if (iface_q)
                spi_pins = serial_pins;
            else
                i2c_pins = serial_pins;
        end
    end
endmodule

// >>> verif/srs_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// far side: loader, calibrator and pll lock
// ----------------------------------------
module srs_host_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] lat,
    input wire logic load_start,
    input wire logic cal_start,
    input wire logic pll_start,
    input wire logic xo_valid,
    output logic load_done,
    output logic cal_done,
    output logic apll_lock
);
    logic [7:0] ld_q;
    logic [7:0] cd_q;
    logic lk_q;
    always_ff @(posedge clk)
    begin
        ld_q <= rst ? 8'h00 : {ld_q[6:0], load_start};
        cd_q <= rst ? 8'h00 : {cd_q[6:0], cal_start};
        lk_q <= rst ? 1'b0 : (lk_q | pll_start) & ~cal_start;
    end
    // lat picks an answer delay of one to eight cycles
    assign load_done = ld_q[lat];
    assign cal_done = cd_q[lat];
    assign apll_lock = lk_q & xo_valid;
endmodule

// >>> verif/srs_monitor.sv
`timescale 1ns/10ps
module srs_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic power_down_n,
    input wire logic core_supply_ok,
    input wire logic soft_reset_bit,
    input wire logic cal_done,
    input wire logic xo_valid,
    input wire logic apll_lock,
    input wire srs_pkg::srs_serial_s serial_pins,
    input wire logic device_enable,
    input wire logic iface_is_spi,
    input wire srs_pkg::srs_page_s rom_page,
    input wire logic use_eeprom,
    input wire logic cal_start,
    input wire logic pll_start,
    input wire logic load_start,
    input wire logic normal_operation,
    input wire srs_pkg::srs_serial_s spi_pins,
    input wire srs_pkg::srs_serial_s i2c_pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    pd_off_a: assert property (!power_down_n [*8] |-> !device_enable)
        else $error("enabled while powered down");
    supply_off_a: assert property (!core_supply_ok [*8] |-> !device_enable)
        else $error("enabled with bad supply");
    load_next_a: assert property ($rose(device_enable) |=> load_start)
        else $error("load did not follow sampling");
    pll_after_cal_a: assert property (pll_start |-> $past(cal_done))
        else $error("pll start without calibration");
    run_lock_a: assert property ($rose(normal_operation) |-> $past(xo_valid && apll_lock))
        else $error("run without lock");
    soft_recal_a: assert property (normal_operation && $rose(soft_reset_bit) |=> cal_start)
        else $error("soft reset missed");
    off_idle_a: assert property (!device_enable |-> spi_pins == 2'h0 && i2c_pins == 2'h3)
        else $error("serial pins pass while off");
    pin_route_a: assert property (normal_operation |-> (iface_is_spi ? spi_pins : i2c_pins) == serial_pins)
        else $error("serial pins misrouted");
    eeprom_pick_a: assert property (use_eeprom ==
        (rom_page.page_a == srs_pkg::TRI_MID || rom_page.page_b == srs_pkg::TRI_MID))
        else $error("eeprom choice wrong");
endmodule

// >>> verif/srs_startup_reset_sequencer_tb.sv
`timescale 1ns/10ps
module srs_startup_reset_sequencer_tb;
    logic clk, rst, power_down_n, core_supply_ok, interface_select_strap, soft_reset_bit, xo_valid;
    logic load_done, cal_done, apll_lock, device_enable, iface_is_spi, use_eeprom;
    logic load_start, cal_start, pll_start, normal_operation;
    logic [2:0] lat;
    srs_pkg::srs_page_s rom_page_strap, rom_page;
    srs_pkg::srs_serial_s serial_pins, spi_pins, i2c_pins;
    int errors, compares, cyc, stg, ncal;
    srs_startup_reset_sequencer dut (.clk, .rst, .power_down_n, .core_supply_ok, .interface_select_strap,
        .rom_page_strap, .soft_reset_bit, .load_done, .cal_done, .xo_valid, .apll_lock, .serial_pins,
        .device_enable, .iface_is_spi, .rom_page, .use_eeprom, .load_start, .cal_start, .pll_start,
        .normal_operation, .spi_pins, .i2c_pins);
    srs_host_model host (.clk, .rst, .lat, .load_start, .cal_start, .pll_start, .xo_valid,
        .load_done, .cal_done, .apll_lock);
    function automatic logic exp_ee(input logic [3:0] p);
        return p[3:2] == srs_pkg::TRI_MID || p[1:0] == srs_pkg::TRI_MID;
    endfunction
    function automatic logic [3:0] exp_pins(input logic spi, input logic [1:0] s);
        return spi ? {s, 2'h3} : {2'h0, s};
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wait_run;
        for (int i = 0; i < 300 && normal_operation !== 1'b1; i++)
            @(negedge clk);
    endtask
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // stage and calibration counts restart whenever the device drops back to off
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (!device_enable)
            stg <= 0;
        else if (load_start)
            stg <= 1;
        else if (cal_start && stg == 1)
            stg <= 2;
        else if (pll_start && stg == 2)
            stg <= 3;
        if (!device_enable)
            ncal <= 0;
        else if (cal_start)
            ncal <= ncal + 1;
    end
    initial
    begin
        {rst, power_down_n, core_supply_ok, interface_select_strap, soft_reset_bit, xo_valid} = 6'h20;
        {lat, rom_page_strap, serial_pins, errors, compares} = '0;
        void'($urandom(16));
        repeat (4) @(negedge clk);
        rst = 0;
        fork
            for (int k = 0; k < 9; k++)
            begin
                {power_down_n, core_supply_ok, soft_reset_bit} = 3'h1;
                repeat (srs_pkg::HARD_RESET_CYC + 1) @(negedge clk);
                soft_reset_bit = 0;
                chk(device_enable, 1'b0);
                power_down_n = 1;
                interface_select_strap = k[0];
                rom_page_strap = {2'(k % 3), 2'(k / 3)};
                lat = 3'($urandom);
                xo_valid = ~k[1];
                repeat (8) @(negedge clk);
                chk(device_enable, 1'b0);
                core_supply_ok = 1;
                if (k[1])
                begin
                    repeat (60) @(negedge clk);
                    chk(normal_operation, 1'b0);
                    xo_valid = 1;
                end
                wait_run;
                chk(normal_operation, 1'b1);
                chk(8'(stg), 8'h3);
                chk({4'h0, rom_page}, {4'h0, 2'(k % 3), 2'(k / 3)});
                chk(use_eeprom, exp_ee(rom_page_strap));
                interface_select_strap = ~k[0];
                rom_page_strap = {2'($urandom % 3), 2'($urandom % 3)};
                serial_pins = 2'($urandom);
                @(negedge clk);
                chk(iface_is_spi, k[0]);
                chk({spi_pins, i2c_pins}, exp_pins(k[0], serial_pins));
                soft_reset_bit = 1;
                @(negedge clk);
                soft_reset_bit = 0;
                wait_run;
                chk(8'(ncal), 8'h2);
                chk(normal_operation, 1'b1);
                $display("test %0d done", k);
            end
            begin
                // a hang counts as a mismatch and ends in the same report
                wait (cyc >= 8000);
                errors++;
            end
        join_any
        stop_test;
    end
endmodule
bind srs_startup_reset_sequencer srs_monitor mon (.clk, .rst, .power_down_n, .core_supply_ok,
    .soft_reset_bit, .cal_done, .xo_valid, .apll_lock, .serial_pins, .device_enable, .iface_is_spi,
    .rom_page, .use_eeprom, .cal_start, .pll_start, .load_start, .normal_operation, .spi_pins, .i2c_pins);
